/* File: pkg/bfr_pkg.sv */
/*
 * Shared constants of the breaker failure / redundant trip sequencer:
 * timing, register map, field positions, reset values and state codes.
 * Assumes a 100 MHz system clock and a 5 ms program cycle.
 */
package bfr_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_MS = 1_000_000;
    localparam int PROG_CYCLE_MS = 5;
    localparam int PROG_CYCLE_CLKS = PROG_CYCLE_MS * NS_PER_MS
                                     / CLK_PERIOD_NS;
    localparam int DELAY_STEP_MS = 5;
    localparam int RETRIP_DLY_DEF_MS = 100;
    localparam int BF_DLY_DEF_MS = 200;
    localparam int RESET_RATIO_PCT = 97;
    localparam int PCT_FULL = 100;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int MAG_W = 16;
    localparam int DLY_W = 19;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int MODE_W = 2;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_PHASE_THR = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_RES_THR = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_RETRIP_DLY = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_BF_DLY = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;

    localparam int CTRL_RETRIP_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_RES_EN_BIT = 3;

    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_START_BIT = 3;
    localparam int STAT_RETRIP_BIT = 4;
    localparam int STAT_BF_BIT = 5;
    localparam int STAT_BLOCKED_BIT = 6;
    localparam int STAT_CUR_PICK_BIT = 7;
    localparam int STAT_TRIP_MON_BIT = 8;
    localparam int STAT_BLK_BIT = 9;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [MAG_W-1:0] PHASE_THR_RST = 16'h0014;
    localparam logic [MAG_W-1:0] RES_THR_RST = 16'h04B0;
    localparam logic [DLY_W-1:0] RETRIP_DLY_RST =
        DLY_W'(RETRIP_DLY_DEF_MS / DELAY_STEP_MS);
    localparam logic [DLY_W-1:0] BF_DLY_RST =
        DLY_W'(BF_DLY_DEF_MS / DELAY_STEP_MS);
    localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CRIT_CURRENT      = 2'b00,
        CRIT_CUR_AND_TRIP = 2'b01,
        CRIT_CUR_OR_TRIP  = 2'b10
    } criterion_t;

    typedef enum logic [2:0] {
        ST_NORMAL  = 3'b000,
        ST_START   = 3'b001,
        ST_RETRIP  = 3'b010,
        ST_BF_ON   = 3'b011,
        ST_BLOCKED = 3'b100
    } bf_state_t;

endpackage : bfr_pkg

/* File: hdl/pickup_comparator.sv */
/*
 * One current pick-up element: magnitude against threshold with a
 * fixed reset ratio, refreshed on each measurement strobe.
 * Assumes magnitude and threshold share one unit, same clock domain.
 */
`timescale 1ns/1ps
module pickup_comparator
    import bfr_pkg::*;
#(
    parameter int W = MAG_W
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // measurement
    input wire logic sample_i,
    input wire logic enable_i,
    input wire logic [W-1:0] mag_i,
    input wire logic [W-1:0] thr_i,
    // result
    output logic pickup_o
);

    localparam int PW = W + 7;

    logic [PW-1:0] mag_scaled;
    logic [PW-1:0] thr_scaled;
    logic pickup_r;

    assign mag_scaled = PW'(mag_i) * PW'(PCT_FULL);
    assign thr_scaled = PW'(thr_i) * PW'(RESET_RATIO_PCT);

    always_ff @(posedge clock_i)
    begin
        if (srst_i || !enable_i)
        begin
            pickup_r <= 1'b0;
        end
        else if (sample_i)
        begin
            if (mag_i > thr_i)
            begin
                pickup_r <= 1'b1;
            end
            // hysteresis: drop only below 97 % of threshold
            else if (mag_scaled < thr_scaled)
            begin
                pickup_r <= 1'b0;
            end
        end
    end

    assign pickup_o = pickup_r;

endmodule : pickup_comparator

/* File: hdl/breaker_failure_retrip_timer.sv */
/*
 * Breaker failure protection sequencer with redundant trip timer.
 * Holds the setting registers, the current pick-up elements, the
 * pick-up criterion, blocking, both delay timers and the status.
 * Assumes current magnitudes arrive from same-clock measurement
 * logic with a strobe every 5 ms; blocking and trip monitor are pins.
 */
// Behaviour
// - status is one of normal, start, retrip, breaker-failure on, blocked
// - blocking input is sampled at the start of each program cycle
// - pick-up without blocking raises start and timing begins
// - pick-up under blocking raises blocked; no timing or outputs follow
// - blocking during start resets both timers and holds blocked until pick-up drops
// - one common pick-up condition starts both timers
// - retrip enable, default on; disabled hides output and delay
// - retrip fires after start held for retrip delay, 5 ms steps
// - fail output fires after start held for fail delay, 5 ms steps
// - current criterion: current pick-up starts timers, trip ignored
// - current criterion: retrip then breaker fail as current persists
// - current criterion: timers reset when all currents drop
// - current-and-trip: timers halted until monitored trip active
// - current-and-trip: reset on current drop or trip release
// - current-or-trip: either current or trip starts timing
// - current-or-trip: reset only when both have released
// - pick-up above threshold, release below 97 % of threshold
// - magnitudes refresh once per 5 ms measurement base
`timescale 1ns/1ps
module breaker_failure_retrip_timer
    import bfr_pkg::*;
#(
    parameter int PROG_CYCLE_LEN = PROG_CYCLE_CLKS,
    parameter int NUM_PHASES = 3
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // measurements
    input wire logic meas_valid_i,
    input wire logic [MAG_W-1:0] phase_a_mag_i,
    input wire logic [MAG_W-1:0] phase_b_mag_i,
    input wire logic [MAG_W-1:0] phase_c_mag_i,
    input wire logic [MAG_W-1:0] residual_mag_i,
    // pins
    input wire logic block_i,
    input wire logic trip_monitor_i,
    // outputs
    output logic start_o,
    output logic redundant_trip_o,
    output logic breaker_fail_output_o,
    output logic blocked_o,
    output logic [2:0] state_o
);

    // ------------------------------------------------------------
    // local declarations
    // ------------------------------------------------------------
    localparam int NCH = NUM_PHASES + 1;
    localparam int TICK_W = $clog2(PROG_CYCLE_LEN + 1);
    localparam logic [DLY_W-1:0] DLY_MAX = '1;

    logic retrip_en_r;
    criterion_t mode_r;
    logic res_en_r;
    logic [MAG_W-1:0] phase_pickup_threshold_r;
    logic [MAG_W-1:0] residual_pickup_threshold_r;
    logic [DLY_W-1:0] redundant_trip_delay_r;
    logic [DLY_W-1:0] bf_delay_r;
    logic [DATA_W-1:0] rdata_r;

    logic blk_meta_r;
    logic blk_sync_r;
    logic trip_meta_r;
    logic trip_sync_r;
    logic blk_sampled_r;

    logic [TICK_W-1:0] tick_cnt_r;
    logic tick_r;

    logic [MAG_W-1:0] chan_mag [NCH];
    logic [MAG_W-1:0] chan_thr [NCH];
    logic [NCH-1:0] chan_en;
    logic [NCH-1:0] chan_pick;
    logic cur_pick;

    logic pick;
    logic run;
    bf_state_t state_r;
    bf_state_t state_nxt;
    logic [DLY_W-1:0] ret_cnt_r;
    logic [DLY_W-1:0] ret_cnt_nxt;
    logic [DLY_W-1:0] bf_cnt_r;
    logic [DLY_W-1:0] bf_cnt_nxt;
    logic ret_fire;
    logic bf_fire;

    logic start_r;
    logic retrip_r;
    logic bf_r;
    logic blocked_r;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            blk_meta_r <= 1'b0;
            blk_sync_r <= 1'b0;
            trip_meta_r <= 1'b0;
            trip_sync_r <= 1'b0;
        end
        else
        begin
            blk_meta_r <= block_i;
            blk_sync_r <= blk_meta_r;
            trip_meta_r <= trip_monitor_i;
            trip_sync_r <= trip_meta_r;
        end
    end

    // ------------------------------------------------------------
    // program cycle tick
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else if (tick_cnt_r == TICK_W'(PROG_CYCLE_LEN - 1))
        begin
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // blocking level frozen for the whole program cycle
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            blk_sampled_r <= 1'b0;
        end
        else if (tick_r)
        begin
            blk_sampled_r <= blk_sync_r;
        end
    end

    // ------------------------------------------------------------
    // setting registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            retrip_en_r <= 1'b1;
            mode_r <= CRIT_CURRENT;
            res_en_r <= 1'b0;
            phase_pickup_threshold_r <= PHASE_THR_RST;
            residual_pickup_threshold_r <= RES_THR_RST;
            redundant_trip_delay_r <= RETRIP_DLY_RST;
            bf_delay_r <= BF_DLY_RST;
        end
        else if (wr_i)
        begin
            case (addr_i)
                ADDR_CTRL:
                begin
                    retrip_en_r <= wdata_i[CTRL_RETRIP_EN_BIT];
                    res_en_r <= wdata_i[CTRL_RES_EN_BIT];
                    // unused code falls back to current only
                    case (wdata_i[CTRL_MODE_LSB +: MODE_W])
                        CRIT_CUR_AND_TRIP: mode_r <= CRIT_CUR_AND_TRIP;
                        CRIT_CUR_OR_TRIP: mode_r <= CRIT_CUR_OR_TRIP;
                        default: mode_r <= CRIT_CURRENT;
                    endcase
                end
                ADDR_PHASE_THR:
                    phase_pickup_threshold_r <= wdata_i[MAG_W-1:0];
                ADDR_RES_THR:
                    residual_pickup_threshold_r <= wdata_i[MAG_W-1:0];
                ADDR_RETRIP_DLY:
                begin
                    // delay is locked while retrip is off
                    if (retrip_en_r)
                    begin
                        redundant_trip_delay_r <= wdata_i[DLY_W-1:0];
                    end
                end
                ADDR_BF_DLY:
                    bf_delay_r <= wdata_i[DLY_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (srst_i || !rd_i)
        begin
            rdata_r <= RDATA_IDLE;
        end
        else
        begin
            rdata_r <= RDATA_IDLE;
            case (addr_i)
                ADDR_CTRL:
                begin
                    rdata_r[CTRL_RETRIP_EN_BIT] <= retrip_en_r;
                    rdata_r[CTRL_MODE_LSB +: MODE_W] <= mode_r;
                    rdata_r[CTRL_RES_EN_BIT] <= res_en_r;
                end
                ADDR_PHASE_THR:
                    rdata_r[MAG_W-1:0] <= phase_pickup_threshold_r;
                ADDR_RES_THR:
                    rdata_r[MAG_W-1:0] <= residual_pickup_threshold_r;
                ADDR_RETRIP_DLY:
                begin
                    if (retrip_en_r)
                    begin
                        rdata_r[DLY_W-1:0] <= redundant_trip_delay_r;
                    end
                end
                ADDR_BF_DLY:
                    rdata_r[DLY_W-1:0] <= bf_delay_r;
                ADDR_STATUS:
                begin
                    rdata_r[STAT_STATE_LSB +: 3] <= state_r;
                    rdata_r[STAT_START_BIT] <= start_r;
                    rdata_r[STAT_RETRIP_BIT] <= retrip_r;
                    rdata_r[STAT_BF_BIT] <= bf_r;
                    rdata_r[STAT_BLOCKED_BIT] <= blocked_r;
                    rdata_r[STAT_CUR_PICK_BIT] <= cur_pick;
                    rdata_r[STAT_TRIP_MON_BIT] <= trip_sync_r;
                    rdata_r[STAT_BLK_BIT] <= blk_sampled_r;
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // current pick-up elements
    // ------------------------------------------------------------
    assign chan_mag[0] = phase_a_mag_i;
    assign chan_mag[1] = phase_b_mag_i;
    assign chan_mag[2] = phase_c_mag_i;
    assign chan_mag[NCH-1] = residual_mag_i;

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_chan
            if (gi < NUM_PHASES)
            begin : g_phase
                assign chan_thr[gi] = phase_pickup_threshold_r;
                assign chan_en[gi] = 1'b1;
            end
            else
            begin : g_res
                assign chan_thr[gi] = residual_pickup_threshold_r;
                assign chan_en[gi] = res_en_r;
            end
            pickup_comparator #(
                .W(MAG_W)
            ) u_pick (
                .clock_i(clock_i),
                .srst_i(srst_i),
                .sample_i(meas_valid_i),
                .enable_i(chan_en[gi]),
                .mag_i(chan_mag[gi]),
                .thr_i(chan_thr[gi]),
                .pickup_o(chan_pick[gi])
            );
        end
    endgenerate

    // any phase or the residual channel picks up
    assign cur_pick = |chan_pick;

    // ------------------------------------------------------------
    // pick-up criterion
    // ------------------------------------------------------------
    // pick drives the start indication, run drives both timers
    always_comb
    begin
        case (mode_r)
            CRIT_CUR_AND_TRIP:
            begin
                pick = cur_pick;
                run = cur_pick && trip_sync_r;
            end
            CRIT_CUR_OR_TRIP:
            begin
                pick = cur_pick || trip_sync_r;
                run = cur_pick || trip_sync_r;
            end
            default:
            begin
                pick = cur_pick;
                run = cur_pick;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer and timers
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        ret_cnt_nxt = ret_cnt_r;
        bf_cnt_nxt = bf_cnt_r;
        ret_fire = 1'b0;
        bf_fire = 1'b0;
        if (tick_r)
        begin
            if (!pick)
            begin
                state_nxt = ST_NORMAL;
                ret_cnt_nxt = '0;
                bf_cnt_nxt = '0;
            end
            // blocked event stays blocked until pick-up drops
            else if (blk_sampled_r || state_r == ST_BLOCKED)
            begin
                state_nxt = ST_BLOCKED;
                ret_cnt_nxt = '0;
                bf_cnt_nxt = '0;
            end
            else
            begin
                // one running condition drives both counters
                if (run && retrip_en_r)
                begin
                    if (ret_cnt_r != DLY_MAX)
                    begin
                        ret_cnt_nxt = ret_cnt_r + 1'b1;
                    end
                end
                else
                begin
                    ret_cnt_nxt = '0;
                end
                if (run)
                begin
                    if (bf_cnt_r != DLY_MAX)
                    begin
                        bf_cnt_nxt = bf_cnt_r + 1'b1;
                    end
                end
                else
                begin
                    bf_cnt_nxt = '0;
                end
                ret_fire = run && retrip_en_r
                           && ret_cnt_nxt >= redundant_trip_delay_r;
                bf_fire = run && bf_cnt_nxt >= bf_delay_r;
                if (bf_fire)
                begin
                    state_nxt = ST_BF_ON;
                end
                else if (ret_fire)
                begin
                    state_nxt = ST_RETRIP;
                end
                else
                begin
                    state_nxt = ST_START;
                end
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_r <= ST_NORMAL;
            ret_cnt_r <= '0;
            bf_cnt_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            ret_cnt_r <= ret_cnt_nxt;
            bf_cnt_r <= bf_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // output flops
    // ------------------------------------------------------------
    // outputs follow the state on the same edge, no extra lag
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            start_r <= 1'b0;
            retrip_r <= 1'b0;
            bf_r <= 1'b0;
            blocked_r <= 1'b0;
        end
        else if (tick_r)
        begin
            start_r <= state_nxt == ST_START
                       || state_nxt == ST_RETRIP
                       || state_nxt == ST_BF_ON;
            retrip_r <= ret_fire;
            bf_r <= bf_fire;
            blocked_r <= state_nxt == ST_BLOCKED;
        end
    end

    assign rdata_o = rdata_r;
    assign start_o = start_r;
    assign redundant_trip_o = retrip_r;
    assign breaker_fail_output_o = bf_r;
    assign blocked_o = blocked_r;
    assign state_o = state_r;

endmodule : breaker_failure_retrip_timer

/* File: tb/bfr_assertions.sv */
/* bound checker for the sequencer, seeing only the top ports
   assumes one clock, synchronous active-high reset, long tick */
`timescale 1ns/1ps
module bfr_assertions
    import bfr_pkg::*;
#(
    parameter int PROG_CYCLE_LEN = PROG_CYCLE_CLKS
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    // outputs
    input wire logic start_o,
    input wire logic redundant_trip_o,
    input wire logic breaker_fail_output_o,
    input wire logic blocked_o,
    input wire logic [2:0] state_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    state_codes_a: assert property (
        state_o inside {ST_NORMAL, ST_START, ST_RETRIP, ST_BF_ON, ST_BLOCKED})
        else $error("illegal state code");
    blocked_code_a: assert property (
        blocked_o == (state_o == ST_BLOCKED)) else $error("blocked code");
    fail_code_a: assert property (
        breaker_fail_output_o == (state_o == ST_BF_ON))
        else $error("fail code");
    blocked_quiet_a: assert property (
        blocked_o |-> !start_o && !redundant_trip_o && !breaker_fail_output_o)
        else $error("output while blocked");
    common_start_a: assert property (
        redundant_trip_o || breaker_fail_output_o |-> start_o)
        else $error("timer output without start");
    release_clear_a: assert property (
        $fell(start_o) |-> !redundant_trip_o && !breaker_fail_output_o)
        else $error("outputs kept after release");
    // only valid while the tick period is at least nine clocks
    tick_hold_a: assert property (
        $changed(state_o) |=> $stable(state_o) [*8])
        else $error("state moved between ticks");
    status_read_a: assert property (
        $past(rd_i) && $past(addr_i) == ADDR_STATUS |->
        rdata_o[2:0] == $past(state_o)) else $error("status readback");
endmodule : bfr_assertions

bind breaker_failure_retrip_timer bfr_assertions #(
    .PROG_CYCLE_LEN(PROG_CYCLE_LEN)
) bfr_assertions_inst (
    .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .start_o(start_o),
    .redundant_trip_o(redundant_trip_o),
    .breaker_fail_output_o(breaker_fail_output_o),
    .blocked_o(blocked_o), .state_o(state_o)
);

/* File: tb/bfr_far_side.sv */
/* far side: measurement strobe, primary trip relay and a breaker
   that opens on the redundant coil; assumes the bench sets levels */
`timescale 1ns/1ps
module bfr_far_side
    import bfr_pkg::*;
#(
    parameter int LEN = 10
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // scenario levels
    input wire logic [MAG_W-1:0] fault_i,
    input wire logic [MAG_W-1:0] res_lvl_i,
    input wire logic trip_i,
    input wire logic coil_ok_i,
    input wire logic redundant_trip_i,
    // towards the block
    output logic meas_valid_o,
    output logic [MAG_W-1:0] phase_mag_o,
    output logic [MAG_W-1:0] res_mag_o,
    output logic trip_monitor_o
);
    int cnt_r;
    logic open_r;

    always_ff @(posedge clock_i)
    begin
        cnt_r <= (srst_i || cnt_r == LEN - 1) ? 0 : cnt_r + 1;
        meas_valid_o <= !srst_i && cnt_r == LEN - 1;
        if (srst_i || (fault_i == '0 && res_lvl_i == '0))
            open_r <= 1'b0;
        else if (coil_ok_i && redundant_trip_i)
            open_r <= 1'b1;
    end

    // between strobes the bus shows junk, not the last value
    assign phase_mag_o = !meas_valid_o ? ~fault_i : open_r ? '0 : fault_i;
    assign res_mag_o = !meas_valid_o ? ~res_lvl_i : open_r ? '0 : res_lvl_i;
    assign trip_monitor_o = trip_i && !open_r;
endmodule : bfr_far_side

/* File: tb/breaker_failure_retrip_timer_tb.sv */
/* self-checking bench of the breaker failure sequencer
   assumes the far-side model and a shortened program cycle */
`timescale 1ns/1ps
module breaker_failure_retrip_timer_tb;
    import bfr_pkg::*;
    localparam int L = 10;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic block_i = 1'b0, trip = 1'b0, coil_ok = 1'b0;
    logic [MAG_W-1:0] fault = '0;
    logic [MAG_W-1:0] res_lvl = '0;
    logic [MAG_W-1:0] ph_mag, res_mag;
    logic [DATA_W-1:0] rdata_o;
    logic meas_valid, trip_mon, st, rt, bf, blk;
    logic [2:0] state_o;
    logic [3:0] outs;
    logic [ADDR_W-1:0] ra [6] = '{ADDR_CTRL, ADDR_PHASE_THR, ADDR_RES_THR,
        ADDR_RETRIP_DLY, ADDR_BF_DLY, 8'h18};
    logic [DATA_W-1:0] rv [6] = '{32'h0000_0001, 32'h0000_0014,
        32'h0000_04B0, 32'h0000_0014, 32'h0000_0028, 32'h0000_0000};
    int n_mismatch = 0, cmp_count = 0, cyc = 0, n;
    assign outs = {blk, bf, rt, st};

    breaker_failure_retrip_timer #(.PROG_CYCLE_LEN(L))
    breaker_failure_retrip_timer_inst (
        .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .meas_valid_i(meas_valid), .phase_a_mag_i(ph_mag),
        .phase_b_mag_i(ph_mag >> 1), .phase_c_mag_i(16'h0000),
        .residual_mag_i(res_mag), .block_i(block_i),
        .trip_monitor_i(trip_mon), .start_o(st), .redundant_trip_o(rt),
        .breaker_fail_output_o(bf), .blocked_o(blk), .state_o(state_o));

    bfr_far_side #(.LEN(L)) bfr_far_side_inst (
        .clock_i(clock_i), .srst_i(srst_i), .fault_i(fault),
        .res_lvl_i(res_lvl), .trip_i(trip), .coil_ok_i(coil_ok),
        .redundant_trip_i(rt), .meas_valid_o(meas_valid),
        .phase_mag_o(ph_mag), .res_mag_o(res_mag),
        .trip_monitor_o(trip_mon));

    initial forever #5 clock_i = ~clock_i;

    // ------------------------------------------------------------
    // access and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask : rd

    // bounded wait for an output, then compare
    task automatic wv(input int b, input logic v, input int lim);
        #1;
        n = 0;
        while (outs[b] !== v && n < lim)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk(32'(outs[b]), 32'(v));
    endtask : wv

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clock_i);
        srst_i <= 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i]);
        wr(ADDR_RETRIP_DLY, 32'h0000_0002);
        wr(ADDR_BF_DLY, 32'h0000_0004);
        trip <= 1'b1;
        repeat (3 * L) @(posedge clock_i);
        wv(0, 1'b0, 0);
        trip <= 1'b0;
        fault <= 16'h0015;
        wv(0, 1'b1, 3 * L);
        wv(1, 1'b1, 2 * L);
        chk(n, L);
        wv(2, 1'b1, 3 * L);
        chk(n, 2 * L);
        rd(ADDR_STATUS, 32'h0000_00BB);
        fault <= 16'h0014;
        repeat (3 * L) @(posedge clock_i);
        wv(2, 1'b1, 0);
        fault <= 16'h0013;
        wv(0, 1'b0, 3 * L);
        wv(2, 1'b0, 0);
        wr(ADDR_CTRL, 32'h0000_0003);
        fault <= 16'h0015;
        wv(0, 1'b1, 3 * L);
        repeat (4 * L) @(posedge clock_i);
        wv(1, 1'b0, 0);
        trip <= 1'b1;
        wv(1, 1'b1, 3 * L);
        trip <= 1'b0;
        wv(1, 1'b0, 3 * L);
        fault <= 16'h0000;
        wv(0, 1'b0, 3 * L);
        wr(ADDR_CTRL, 32'h0000_0005);
        trip <= 1'b1;
        wv(0, 1'b1, 3 * L);
        fault <= 16'h0015;
        repeat (2 * L) @(posedge clock_i);
        trip <= 1'b0;
        repeat (3 * L) @(posedge clock_i);
        wv(0, 1'b1, 0);
        fault <= 16'h0000;
        wv(0, 1'b0, 3 * L);
        wr(ADDR_CTRL, 32'h0000_0001);
        block_i <= 1'b1;
        repeat (2 * L) @(posedge clock_i);
        fault <= 16'h0015;
        wv(3, 1'b1, 3 * L);
        block_i <= 1'b0;
        repeat (3 * L) @(posedge clock_i);
        wv(3, 1'b1, 0);
        fault <= 16'h0000;
        wv(3, 1'b0, 3 * L);
        fault <= 16'h0015;
        wv(0, 1'b1, 3 * L);
        block_i <= 1'b1;
        wv(3, 1'b1, 3 * L);
        repeat (2 * L) @(posedge clock_i);
        wv(2, 1'b0, 0);
        block_i <= 1'b0;
        fault <= 16'h0000;
        wv(3, 1'b0, 3 * L);
        wr(ADDR_CTRL, 32'h0000_0000);
        rd(ADDR_RETRIP_DLY, 32'h0000_0000);
        fault <= 16'h0015;
        wv(2, 1'b1, 5 * L);
        wv(1, 1'b0, 0);
        fault <= 16'h0000;
        wv(0, 1'b0, 3 * L);
        wr(ADDR_CTRL, 32'h0000_0009);
        wr(ADDR_RETRIP_DLY, 32'h0000_0002);
        coil_ok <= 1'b1;
        res_lvl <= 16'h04B1;
        wv(0, 1'b1, 3 * L);
        wv(1, 1'b1, 3 * L);
        wv(0, 1'b0, 3 * L);
        wv(2, 1'b0, 0);
        print_verdict();
    end
endmodule : breaker_failure_retrip_timer_tb
